/* logic/patb_pkg.sv */
// Package for the peripheral access timing bridge
package patb_pkg;
   localparam int PATB_AW = 32;
   localparam int PATB_DW = 16;
   // Access sizes
   localparam logic [1:0] PATB_SZ_8 = 2'h1;
   localparam logic [1:0] PATB_SZ_16 = 2'h2;
   localparam logic [1:0] PATB_SZ_32 = 2'h3;
   // Address windows of the decoded register groups
   localparam logic [31:0] PATB_ODR_LO = 32'h0008c080;
   localparam logic [31:0] PATB_ODR_HI = 32'h0008c0a5;
   localparam logic [31:0] PATB_CRC_CTRL = 32'h00088280;
   localparam logic [31:0] PATB_CRC_DIN = 32'h00088281;
   localparam logic [31:0] PATB_CRC_DOUT = 32'h00088282;
   localparam logic [31:0] PATB_SHARED_ADDR = 32'h0008830a;
   // Bus regions: peripheral bus 1 needs no divided clock sync
   localparam logic [31:0] PATB_PB1_LO = 32'h00080000;
   localparam logic [31:0] PATB_PB1_HI = 32'h00087fff;
   localparam logic [31:0] PATB_EXB_LO = 32'h00081300;
   localparam logic [31:0] PATB_EXB_HI = 32'h000813ff;
   localparam logic [31:0] PATB_EXB_ERR_LO = 32'h00081300;
   localparam logic [31:0] PATB_EXB_ERR_HI = 32'h0008130f;
   // Cycle counts
   localparam logic [3:0] PATB_MAIN_BUS_CYC = 4'h1;
   localparam logic [3:0] PATB_PERI_CYC_MIN = 4'h2;
   localparam logic [3:0] PATB_PERI_CYC_MAX = 4'h3;
   localparam logic [3:0] PATB_SLOW_CORE_CYC = 4'h2;
   localparam logic [3:0] PATB_RST_CNT = 4'h0;
   localparam logic [3:0] PATB_DIV_RST = 4'h0;

   typedef struct packed {
      logic [PATB_AW-1:0] addr;
      logic [PATB_DW-1:0] wdata;
      logic [1:0] size;
      logic write;
   } patb_req_s;

   typedef struct packed {
      logic [PATB_DW-1:0] rdata;
      logic unsupported;
   } patb_rsp_s;

   typedef enum logic [3:0] {
      PATB_IDLE = 4'b0001,
      PATB_SYNC = 4'b0010,
      PATB_PERI = 4'b0100,
      PATB_DONE = 4'b1000
   } patb_state_e;
endpackage : patb_pkg

/* logic/patb_clk_tick.sv */
// Divided clock edge generator for peripheral and external bus clocks
`timescale 1ns/10ps
`default_nettype none
module patb_clk_tick
   import patb_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [3:0] ratio_in,
   output logic tick_out
);
   logic [3:0] div_r;
   logic [3:0] div_nxt;
   logic tick_nxt;

   always_comb begin
      tick_nxt = 1'b0;
      if (div_r >= ratio_in) begin
         div_nxt = PATB_DIV_RST;
         tick_nxt = 1'b1;
      end else begin
         div_nxt = div_r + 4'h1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         div_r <= PATB_DIV_RST;
         tick_out <= 1'b0;
      end else begin
         div_r <= div_nxt;
         tick_out <= tick_nxt;
      end
   end
endmodule : patb_clk_tick
`default_nettype wire

/* logic/patb_bridge.sv */
// Bridge from main internal bus to peripheral buses with access timing
//
// Overview of operation
// - Access cycles are main bus plus sync plus addressed peripheral bus cycles.
// - Sync cycles are added only for buses 2-6 and non-error external bus registers.
// - Fast core: main bus plus sync fit within one peripheral clock cycle.
// - Slow core: next access starts on core cycle after peripheral access ends.
// - External bus registers: main bus plus sync fit within one bus clock.
// - Counts hold only without contention from fetches or other masters.
// - Read of last-written register returns only after all earlier writes finish.
// - Byte registers take 2 or 3 peripheral clocks, or 2 core clocks if slow.
// - Open-drain control registers accept byte and halfword accesses.
// - Checksum output is halfword only; its neighbours are byte only.
// - Shared address selects slave address low or timeout counter low.
`timescale 1ns/10ps
`default_nettype none
module patb_bridge
   import patb_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Master side
   input wire logic req_valid_in,
   input wire patb_req_s req_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output patb_rsp_s rsp_out,
   // Clock relationship: divided clock ratio minus one, zero for equal rate
   input wire logic [3:0] peri_ratio_in,
   input wire logic [3:0] bus_ratio_in,
   input wire logic core_slower_in,
   input wire logic timeout_sel_in,
   input wire logic contention_in,
   // Peripheral side
   output logic peri_sel_out,
   output logic peri_write_out,
   output logic [PATB_AW-1:0] peri_addr_out,
   output logic [PATB_DW-1:0] peri_wdata_out,
   output logic [1:0] peri_size_out,
   output logic peri_timeout_sel_out,
   input wire logic [PATB_DW-1:0] peri_rdata_in,
   input wire logic peri_wait_in
);
   patb_state_e state_r;
   patb_state_e state_nxt;
   patb_req_s hold_r;
   patb_req_s hold_nxt;
   patb_rsp_s rsp_r;
   patb_rsp_s rsp_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic need_sync_r;
   logic need_sync_nxt;
   logic ext_r;
   logic ext_nxt;
   logic tsel_r;
   logic tsel_nxt;
   logic rsp_valid_r;
   logic rsp_valid_nxt;
   logic peri_tick;
   logic bus_tick;
   logic div_tick;
   logic in_pb1;
   logic in_exb;
   logic in_exb_err;
   logic size_ok;
   logic cont_s1_r;
   logic cont_s2_r;

   patb_clk_tick u_peri_tick (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .ratio_in(peri_ratio_in),
      .tick_out(peri_tick)
   );

   patb_clk_tick u_bus_tick (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .ratio_in(bus_ratio_in),
      .tick_out(bus_tick)
   );

   // Contention flag comes from another master's arbiter domain
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         cont_s1_r <= 1'b0;
         cont_s2_r <= 1'b0;
      end else begin
         cont_s1_r <= contention_in;
         cont_s2_r <= cont_s1_r;
      end
   end

   always_comb begin
      in_pb1 = (req_in.addr >= PATB_PB1_LO) && (req_in.addr <= PATB_PB1_HI);
      in_exb = (req_in.addr >= PATB_EXB_LO) && (req_in.addr <= PATB_EXB_HI);
      in_exb_err = (req_in.addr >= PATB_EXB_ERR_LO) && (req_in.addr <= PATB_EXB_ERR_HI);
   end

   // Width check per register group
   always_comb begin
      size_ok = 1'b1;
      if ((req_in.addr >= PATB_ODR_LO) && (req_in.addr <= PATB_ODR_HI)) begin
         size_ok = (req_in.size == PATB_SZ_8) || (req_in.size == PATB_SZ_16);
      end else if (req_in.addr == PATB_CRC_DOUT) begin
         size_ok = (req_in.size == PATB_SZ_16);
      end else if ((req_in.addr == PATB_CRC_CTRL) || (req_in.addr == PATB_CRC_DIN)) begin
         size_ok = (req_in.size == PATB_SZ_8);
      end else if (!in_pb1 && !in_exb) begin
         size_ok = (req_in.size == PATB_SZ_8);
      end
   end

   // Non-error external bus registers sync to the bus clock, buses 2-6 to the peripheral clock
   assign div_tick = ext_r ? bus_tick : peri_tick;

   // One access in flight at a time: a write must finish before the next request
   // is taken, so a read-back of the last write implies every earlier write is done.
   assign req_ready_out = (state_r == PATB_IDLE);

   always_comb begin
      state_nxt = state_r;
      hold_nxt = hold_r;
      rsp_nxt = rsp_r;
      cnt_nxt = cnt_r;
      need_sync_nxt = need_sync_r;
      ext_nxt = ext_r;
      tsel_nxt = tsel_r;
      rsp_valid_nxt = 1'b0;
      case (state_r)
         PATB_IDLE: begin
            if (req_valid_in) begin
               hold_nxt = req_in;
               // Sync only for buses 2-6 and non-error external bus registers
               need_sync_nxt = !in_pb1 || (in_exb && !in_exb_err);
               ext_nxt = in_exb && !in_exb_err;
               tsel_nxt = (req_in.addr == PATB_SHARED_ADDR) && timeout_sel_in;
               rsp_nxt.unsupported = !size_ok;
               cnt_nxt = PATB_MAIN_BUS_CYC;
               state_nxt = PATB_SYNC;
            end
         end
         PATB_SYNC: begin
            // Main bus cycle done; wait for a divided edge, at most one slow clock
            if (cnt_r != PATB_RST_CNT) begin
               cnt_nxt = cnt_r - 4'h1;
            end else if (!need_sync_r || core_slower_in || div_tick) begin
               cnt_nxt = core_slower_in ? PATB_SLOW_CORE_CYC : PATB_PERI_CYC_MIN;
               state_nxt = PATB_PERI;
            end
         end
         PATB_PERI: begin
            // Count peripheral cycles in divided ticks, or core clocks if core is slower or no sync is needed
            if ((core_slower_in || !need_sync_r || div_tick) && cnt_r != PATB_RST_CNT) begin
               cnt_nxt = cnt_r - 4'h1;
            end
            if (cnt_r == PATB_RST_CNT && !peri_wait_in && !cont_s2_r) begin
               rsp_nxt.rdata = hold_r.write ? '0 : peri_rdata_in;
               state_nxt = PATB_DONE;
            end
         end
         PATB_DONE: begin
            // Answer on the core cycle after the peripheral access ends
            rsp_valid_nxt = 1'b1;
            state_nxt = PATB_IDLE;
         end
         default: begin
            state_nxt = PATB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         state_r <= PATB_IDLE;
         hold_r <= '0;
         rsp_r <= '0;
         cnt_r <= PATB_RST_CNT;
         need_sync_r <= 1'b0;
         ext_r <= 1'b0;
         tsel_r <= 1'b0;
         rsp_valid_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         hold_r <= hold_nxt;
         rsp_r <= rsp_nxt;
         cnt_r <= cnt_nxt;
         need_sync_r <= need_sync_nxt;
         ext_r <= ext_nxt;
         tsel_r <= tsel_nxt;
         rsp_valid_r <= rsp_valid_nxt;
      end
   end

   assign rsp_valid_out = rsp_valid_r;
   assign rsp_out = rsp_r;
   assign peri_sel_out = (state_r == PATB_PERI);
   assign peri_write_out = hold_r.write;
   assign peri_addr_out = hold_r.addr;
   assign peri_wdata_out = hold_r.wdata;
   assign peri_size_out = hold_r.size;
   assign peri_timeout_sel_out = tsel_r;
endmodule : patb_bridge
`default_nettype wire

/* sim/patb_bridge_asserts.sv */
// Checker for the bridge handshake, decode and answer timing
`timescale 1ns/10ps
`default_nettype none
module patb_bridge_asserts
   import patb_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic req_valid_in,
   input wire patb_req_s req_in,
   input wire logic req_ready_out,
   input wire logic rsp_valid_out,
   input wire patb_rsp_s rsp_out,
   input wire logic timeout_sel_in,
   input wire logic peri_sel_out,
   input wire logic [PATB_AW-1:0] peri_addr_out,
   input wire logic [1:0] peri_size_out,
   input wire logic peri_timeout_sel_out,
   input wire logic peri_wait_in
);
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   wire logic tk = req_valid_in && req_ready_out;
   wire logic crc = peri_addr_out == PATB_CRC_DOUT;
   wire logic bad = peri_size_out != PATB_SZ_16;
   take_busy_a: assert property (tk |=> !req_ready_out)
      else $error("ready after take");
   rsp_pulse_a: assert property (rsp_valid_out |=> !rsp_valid_out)
      else $error("answer too long");
   rsp_idle_a: assert property (rsp_valid_out |-> req_ready_out)
      else $error("answer not idle");
   sel_busy_a: assert property (peri_sel_out |-> !req_ready_out)
      else $error("select when idle");
   addr_copy_a: assert property (tk |=> peri_addr_out == $past(req_in.addr))
      else $error("address lost");
   shared_sel_a: assert property (tk |=> peri_timeout_sel_out ==
      ($past(timeout_sel_in) && ($past(req_in.addr) == PATB_SHARED_ADDR)))
      else $error("shared select lost");
   wait_hold_a: assert property (peri_sel_out && peri_wait_in |=> !rsp_valid_out)
      else $error("answer in wait");
   crc_width_a: assert property (rsp_valid_out && crc |-> rsp_out.unsupported == bad)
      else $error("checksum width flag");
endmodule : patb_bridge_asserts
`default_nettype wire

/* sim/patb_peri_model.sv */
// Peripheral register model with a settable wait
`timescale 1ns/10ps
`default_nettype none
module patb_peri_model import patb_pkg::*; (
   input wire logic clk_in,
   input wire logic sel_in,
   input wire logic write_in,
   input wire logic [7:0] addr_in,
   input wire logic [PATB_DW-1:0] wdata_in,
   input wire logic [1:0] wait_cyc_in,
   output logic [PATB_DW-1:0] rdata_out,
   output logic wait_out
);
   logic [PATB_DW-1:0] mem_r [256] = '{default: 16'h0};
   logic [1:0] cnt_r = 2'h0;
   assign wait_out = sel_in && cnt_r != wait_cyc_in;
   // Inverted when deselected so a late data capture cannot pass
   assign rdata_out = sel_in ? mem_r[addr_in] : ~mem_r[addr_in];
   always @(posedge clk_in) begin
      cnt_r <= sel_in ? cnt_r + 2'(wait_out) : 2'h0;
      if (sel_in && write_in && !wait_out)
         mem_r[addr_in] <= wdata_in;
   end
endmodule : patb_peri_model
`default_nettype wire

/* sim/testbench.sv */
// Bench: table of accesses, then stall and mid-run reset cases
`timescale 1ns/10ps
`default_nettype none
module testbench import patb_pkg::*; ;
   typedef struct {patb_req_s q; logic [3:0] r, c, lo, hi; logic u;} patb_row_s;
   logic clk_in, rst_b_in, req_valid_in, req_ready_out, rsp_valid_out, peri_sel_out;
   logic core_slower_in, timeout_sel_in, contention_in, peri_write_out, peri_timeout_sel_out;
   logic peri_wait_in;
   logic [3:0] peri_ratio_in, bus_ratio_in;
   logic [1:0] peri_size_out, wc;
   logic [PATB_DW-1:0] peri_wdata_out, peri_rdata_in;
   logic [PATB_AW-1:0] peri_addr_out;
   patb_req_s req_in;
   patb_rsp_s rsp_out;
   int mismatches = 0, compares = 0, n;
   // Ratio nibble: bus ratio high bits, peripheral ratio low bits
   patb_row_s rows [9] = '{
      '{'{32'h8c080, 16'h1234, 2'h2, 1'b1}, 4'h0, 4'h0, 4'h4, 4'h9, 1'b0},
      '{'{32'h8c080, 16'h1234, 2'h2, 1'b0}, 4'h0, 4'h0, 4'h4, 4'h9, 1'b0},
      '{'{32'h8c080, 16'h0, 2'h3, 1'b0}, 4'h0, 4'h0, 4'h1, 4'hc, 1'b1},
      '{'{32'h88282, 16'h00a5, 2'h2, 1'b1}, 4'h0, 4'h2, 4'h5, 4'he, 1'b0},
      '{'{32'h88282, 16'h0, 2'h1, 1'b0}, 4'h0, 4'h0, 4'h1, 4'hc, 1'b1},
      '{'{32'h8830a, 16'h0, 2'h1, 1'b0}, 4'h0, 4'h4, 4'h4, 4'h9, 1'b0},
      '{'{32'h81300, 16'h0, 2'h1, 1'b0}, 4'hc, 4'h0, 4'h4, 4'h9, 1'b0},
      '{'{32'h8c090, 16'h0, 2'h1, 1'b0}, 4'h1, 4'h0, 4'h4, 4'hf, 1'b0},
      '{'{32'h80010, 16'h0, 2'h1, 1'b0}, 4'h0, 4'h8, 4'h3, 4'h7, 1'b0}};
   patb_bridge dut (.*);
   patb_peri_model u_peri (.clk_in(clk_in), .sel_in(peri_sel_out), .write_in(peri_write_out),
      .addr_in(peri_addr_out[7:0]), .wdata_in(peri_wdata_out), .wait_cyc_in(wc),
      .rdata_out(peri_rdata_in), .wait_out(peri_wait_in));
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test
   // Only called when idle, so the request is taken at the next edge
   task automatic send(input patb_req_s q);
      req_in = q;
      req_valid_in = 1'b1;
      @(negedge clk_in);
      req_valid_in = 1'b0;
      for (n = 1; rsp_valid_out !== 1'b1; n++) begin
         mismatches += int'(n == 40);
         if (n == 40)
            stop_test();
         @(negedge clk_in);
      end
   endtask : send
   initial begin
      {rst_b_in, req_valid_in, contention_in, core_slower_in, timeout_sel_in} = 5'h0;
      {peri_ratio_in, bus_ratio_in, wc} = 10'h0;
      req_in = '0;
      repeat (10) @(negedge clk_in);
      rst_b_in = 1'b1;
      foreach (rows[i]) begin
         {bus_ratio_in, peri_ratio_in} = {2'h0, rows[i].r[3:2], 2'h0, rows[i].r[1:0]};
         {core_slower_in, timeout_sel_in, wc} = rows[i].c;
         send(rows[i].q);
         chk("unsupported", rows[i].u, rsp_out.unsupported);
         if (!rows[i].u)
            chk("data", rows[i].q.write ? 16'h0 : rows[i].q.wdata, rsp_out.rdata);
         chk("latency", 1'b1, n >= rows[i].lo && n <= rows[i].hi);
         chk("shared select", timeout_sel_in && rows[i].q.addr == PATB_SHARED_ADDR, peri_timeout_sel_out);
         $display("row %0d done", i);
      end
      contention_in = 1'b1;
      fork
         send(rows[1].q);
         begin
            repeat (12) @(negedge clk_in);
            contention_in = 1'b0;
         end
      join
      chk("stall", 1'b1, n > 12);
      $display("stall test done");
      req_valid_in = 1'b1;
      @(negedge clk_in);
      {req_valid_in, rst_b_in} = 2'h0;
      @(negedge clk_in);
      chk("reset", 16'h4, {req_ready_out, rsp_valid_out, peri_sel_out});
      // Second release in mid-run: the first request follows at once
      rst_b_in = 1'b1;
      send(rows[1].q);
      chk("after reset", rows[1].q.wdata, rsp_out.rdata);
      $display("reset test done");
      stop_test();
   end
endmodule : testbench
bind patb_bridge patb_bridge_asserts u_chk (.*);
`default_nettype wire
